// File: logic/flash_status_pkg.sv
// Opcodes, status field layout, reset values and timing for the status logic
package flash_status_pkg;
  localparam logic [7:0] WRITE_REGS_OP   = 8'h01;
  localparam logic [7:0] READ_STATUS_OP  = 8'h05;
  localparam logic [7:0] SET_LATCH_OP    = 8'h06;
  localparam logic [7:0] CLEAR_LATCH_OP  = 8'h04;
  localparam logic [7:0] CLEAR_STATUS_OP = 8'h30;

  localparam int LOCK_BIT = 7;
  localparam int PERR_BIT = 6;
  localparam int EERR_BIT = 5;
  localparam int BP_MSB   = 4;
  localparam int BP_LSB   = 2;
  localparam int WEL_BIT  = 1;
  localparam int BUSY_BIT = 0;

  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [2:0] BP_VOL_RESET  = 3'h7;
  localparam logic [2:0] BP_NV_RESET   = 3'h0;

  localparam int CLK_NS           = 50;
  localparam int REG_WRITE_NS     = 800;
  localparam int REG_WRITE_CYCLES = (REG_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REG_CNT_W        = $clog2(REG_WRITE_CYCLES + 1);

  typedef enum logic [1:0] {
    KIND_PROG   = 2'b00,
    KIND_SECTOR = 2'b01,
    KIND_BULK   = 2'b10
  } op_kind_type;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_REG_WRITE = 2'b01,
    ST_ARRAY     = 2'b10
  } ctrl_state_type;
endpackage

// File: logic/flash_status_register_logic.sv
// Status register, command gating and serial link of the flash device
`timescale 1ns/100ps
module flash_status_register_logic #(
  parameter logic [7:0] PROGRAM_OP      = 8'ha1,
  parameter logic [7:0] SECTOR_ERASE_OP = 8'ha2,
  parameter logic [7:0] BULK_ERASE_OP   = 8'ha3,
  parameter logic [7:0] SOFT_RESET_OP   = 8'ha4,
  parameter logic [7:0] ERASE_SUSP_OP   = 8'ha5,
  parameter logic [7:0] PROG_SUSP_OP    = 8'ha6
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       sck,
  input  wire logic       csN,
  input  wire logic       mosi,
  input  wire logic       wpN,
  input  wire logic       bpVolatile,
  input  wire logic       areaProtected,
  input  wire logic       opDone,
  input  wire logic       opFail,
  input  wire logic       protHit,
  output logic            misoData,
  output logic            misoOeN,
  output logic            opStart,
  output logic [1:0]      opKind,
  output logic            suspendReq,
  output logic [7:0]      statusOut
);
  typedef struct packed {
    logic [2:0] bitCnt;
    logic [1:0] byteCnt;
    logic [6:0] shift;
  } frame_type;

  typedef struct packed {
    logic [7:0] rxCmd;
    logic [7:0] rxData;
    logic       cmdTgl;
    logic       dataTgl;
    logic [7:0] stA;
    logic [7:0] stB;
  } hold_type;

  typedef struct packed {
    logic [7:0] data;
    logic       oeN;
  } out_type;

  typedef struct packed {
    logic [1:0]                          wpS;
    logic [3:0]                          csS;
    logic [2:0]                          cmdS;
    logic [2:0]                          datS;
    logic [7:0]                          cmd;
    logic [7:0]                          data;
    logic                                cmdSeen;
    logic                                dataSeen;
    logic                                lock;
    logic                                pErr;
    logic                                eErr;
    logic [2:0]                          nvBp;
    logic [2:0]                          volBp;
    logic                                write_enable_latch;
    flash_status_pkg::ctrl_state_type    st;
    flash_status_pkg::op_kind_type       kind;
    logic [flash_status_pkg::REG_CNT_W-1:0] cnt;
    logic                                start;
    logic                                susp;
    logic [7:0]                          status;
  } ctl_type;

  frame_type frameQ, frameD;
  hold_type  holdQ, holdD;
  out_type   outQ, outD;
  ctl_type   ctlQ, ctlD;
  logic      frameClr;
  logic      byteDone;
  logic      busy;
  logic      locked;
  logic      execNow;
  logic [2:0] bpNow;

  // Chip select ends a frame asynchronously: the link clock is idle then
  assign frameClr = csN | srst;
  assign byteDone = (frameQ.bitCnt == 3'h7);

  always_comb begin
    frameD = frameQ;
    frameD.shift = {frameQ.shift[5:0], mosi};
    frameD.bitCnt = frameQ.bitCnt + 3'h1;
    if (byteDone && frameQ.byteCnt != 2'h3) begin
      frameD.byteCnt = frameQ.byteCnt + 2'h1;
    end
  end

  always_ff @(posedge sck or posedge frameClr) begin
    if (frameClr) begin
      frameQ <= '0;
    end else begin
      frameQ <= frameD;
    end
  end

  // Bytes are held to the next frame so the slow clock can pick them up
  always_comb begin
    holdD = holdQ;
    holdD.stA = ctlQ.status;
    holdD.stB = holdQ.stA;
    if (byteDone && frameQ.byteCnt == 2'h0) begin
      holdD.rxCmd = {frameQ.shift, mosi};
      holdD.cmdTgl = ~holdQ.cmdTgl;
    end
    if (byteDone && frameQ.byteCnt == 2'h1) begin
      holdD.rxData = {frameQ.shift, mosi};
      holdD.dataTgl = ~holdQ.dataTgl;
    end
  end

  always_ff @(posedge sck or posedge srst) begin
    if (srst) begin
      holdQ <= '0;
    end else begin
      holdQ <= holdD;
    end
  end

  // Status reloads at each byte boundary so polling sees fresh busy state
  always_comb begin
    outD.oeN = 1'b0;
    outD.data = {outQ.data[6:0], 1'b0};
    if (frameQ.bitCnt == 3'h0 && frameQ.byteCnt != 2'h0 &&
        holdQ.rxCmd == flash_status_pkg::READ_STATUS_OP) begin
      outD.data = holdQ.stB;
    end
  end

  always_ff @(negedge sck or posedge frameClr) begin
    if (frameClr) begin
      outQ <= {8'h00, 1'b1};
    end else begin
      outQ <= outD;
    end
  end

  assign misoData = outQ.data[7];
  assign misoOeN  = outQ.oeN;

  assign busy    = ctlQ.st != flash_status_pkg::ST_IDLE || ctlQ.pErr || ctlQ.eErr;
  assign locked  = ctlQ.lock && !ctlQ.wpS[1];
  // One stage more than the toggle sync, so the command is always seen before the frame end
  assign execNow = ctlQ.csS[2] && !ctlQ.csS[3] && ctlQ.cmdSeen;
  assign bpNow   = bpVolatile ? ctlQ.volBp : ctlQ.nvBp;

  always_comb begin
    logic softRst;
    logic [2:0] bpD;
    softRst = 1'b0;
    bpD = 3'h0;
    ctlD = ctlQ;
    ctlD.start = 1'b0;
    ctlD.susp = 1'b0;
    ctlD.wpS = {ctlQ.wpS[0], wpN};
    ctlD.csS = {ctlQ.csS[2:0], csN};
    ctlD.cmdS = {ctlQ.cmdS[1:0], holdQ.cmdTgl};
    ctlD.datS = {ctlQ.datS[1:0], holdQ.dataTgl};
    if (ctlQ.cmdS[2] != ctlQ.cmdS[1]) begin
      ctlD.cmd = holdQ.rxCmd;
      ctlD.cmdSeen = 1'b1;
      ctlD.dataSeen = 1'b0;
    end
    // Polling reads during a register write must not replace the pending data byte
    if (ctlQ.datS[2] != ctlQ.datS[1] && ctlQ.st != flash_status_pkg::ST_REG_WRITE) begin
      ctlD.data = holdQ.rxData;
      ctlD.dataSeen = 1'b1;
    end
    if (execNow) begin
      ctlD.cmdSeen = 1'b0;
      ctlD.dataSeen = 1'b0;
      if (ctlQ.cmd == flash_status_pkg::CLEAR_STATUS_OP) begin
        ctlD.pErr = 1'b0;
        ctlD.eErr = 1'b0;
      end else if (ctlQ.cmd == SOFT_RESET_OP) begin
        softRst = 1'b1;
        ctlD.write_enable_latch = 1'b0;
        ctlD.pErr = 1'b0;
        ctlD.eErr = 1'b0;
        ctlD.volBp = flash_status_pkg::BP_VOL_RESET;
        ctlD.st = flash_status_pkg::ST_IDLE;
      end else if (ctlQ.cmd == ERASE_SUSP_OP) begin
        ctlD.susp = ctlQ.st == flash_status_pkg::ST_ARRAY &&
                    ctlQ.kind != flash_status_pkg::KIND_PROG;
      end else if (ctlQ.cmd == PROG_SUSP_OP) begin
        ctlD.susp = ctlQ.st == flash_status_pkg::ST_ARRAY &&
                    ctlQ.kind == flash_status_pkg::KIND_PROG;
      end else if (!busy) begin
        if (ctlQ.cmd == flash_status_pkg::SET_LATCH_OP) begin
          ctlD.write_enable_latch = 1'b1;
        end else if (ctlQ.cmd == flash_status_pkg::CLEAR_LATCH_OP) begin
          ctlD.write_enable_latch = 1'b0;
        end else if (ctlQ.cmd == flash_status_pkg::WRITE_REGS_OP) begin
          if (ctlQ.write_enable_latch && ctlQ.dataSeen && !locked) begin
            ctlD.st = flash_status_pkg::ST_REG_WRITE;
            ctlD.cnt = flash_status_pkg::REG_CNT_W'(flash_status_pkg::REG_WRITE_CYCLES - 1);
          end
        end else if (ctlQ.cmd == PROGRAM_OP && ctlQ.write_enable_latch) begin
          if (areaProtected) begin
            ctlD.pErr = 1'b1;
          end else begin
            ctlD.st = flash_status_pkg::ST_ARRAY;
            ctlD.kind = flash_status_pkg::KIND_PROG;
            ctlD.start = 1'b1;
          end
        end else if (ctlQ.cmd == SECTOR_ERASE_OP && ctlQ.write_enable_latch) begin
          if (areaProtected) begin
            ctlD.eErr = 1'b1;
          end else begin
            ctlD.st = flash_status_pkg::ST_ARRAY;
            ctlD.kind = flash_status_pkg::KIND_SECTOR;
            ctlD.start = 1'b1;
          end
        end else if (ctlQ.cmd == BULK_ERASE_OP && ctlQ.write_enable_latch && bpNow == 3'h0) begin
          ctlD.st = flash_status_pkg::ST_ARRAY;
          ctlD.kind = flash_status_pkg::KIND_BULK;
          ctlD.start = 1'b1;
        end
      end
    end
    // Completion comes after the clear so a coinciding error still sets
    if (!softRst && ctlQ.st == flash_status_pkg::ST_REG_WRITE) begin
      if (ctlQ.cnt == '0) begin
        ctlD.lock = ctlQ.data[flash_status_pkg::LOCK_BIT];
        if (bpVolatile) begin
          ctlD.volBp = ctlQ.data[flash_status_pkg::BP_MSB:flash_status_pkg::BP_LSB];
        end else begin
          ctlD.nvBp = ctlQ.data[flash_status_pkg::BP_MSB:flash_status_pkg::BP_LSB];
        end
        ctlD.write_enable_latch = 1'b0;
        ctlD.st = flash_status_pkg::ST_IDLE;
      end else begin
        ctlD.cnt = ctlQ.cnt - 1'b1;
      end
    end
    if (!softRst && ctlQ.st == flash_status_pkg::ST_ARRAY && opDone) begin
      ctlD.st = flash_status_pkg::ST_IDLE;
      if (opFail || (protHit && ctlQ.kind != flash_status_pkg::KIND_BULK)) begin
        if (ctlQ.kind == flash_status_pkg::KIND_PROG) begin
          ctlD.pErr = 1'b1;
        end else begin
          ctlD.eErr = 1'b1;
        end
      end else begin
        ctlD.write_enable_latch = 1'b0;
      end
    end
    bpD = bpVolatile ? ctlD.volBp : ctlD.nvBp;
    ctlD.status = {ctlD.lock, ctlD.pErr, ctlD.eErr, bpD, ctlD.write_enable_latch,
                   ctlD.st != flash_status_pkg::ST_IDLE || ctlD.pErr || ctlD.eErr};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctlQ <= '0;
      ctlQ.csS <= 4'hf;
      ctlQ.nvBp <= flash_status_pkg::BP_NV_RESET;
      ctlQ.volBp <= flash_status_pkg::BP_VOL_RESET;
      ctlQ.status <= flash_status_pkg::STATUS_RESET;
    end else begin
      ctlQ <= ctlD;
    end
  end

  assign opStart    = ctlQ.start;
  assign opKind     = ctlQ.kind;
  assign suspendReq = ctlQ.susp;
  assign statusOut  = ctlQ.status;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  lock_ignore_a: assert property (execNow && !busy && locked &&
    ctlQ.cmd == flash_status_pkg::WRITE_REGS_OP |=> ctlQ.st == flash_status_pkg::ST_IDLE)
    else $error("locked register write started");
  reg_write_a: assert property (execNow && !busy && ctlQ.write_enable_latch && ctlQ.dataSeen && !locked &&
    ctlQ.cmd == flash_status_pkg::WRITE_REGS_OP |=> ctlQ.st == flash_status_pkg::ST_REG_WRITE)
    else $error("register write not started");
  prog_error_a: assert property (execNow && !busy && ctlQ.write_enable_latch && areaProtected &&
    ctlQ.cmd == PROGRAM_OP |=> ctlQ.pErr && !ctlQ.start)
    else $error("protected program not flagged");
  erase_error_a: assert property (execNow && !busy && ctlQ.write_enable_latch && areaProtected &&
    ctlQ.cmd == SECTOR_ERASE_OP |=> ctlQ.eErr && !ctlQ.start)
    else $error("protected erase not flagged");
  bulk_quiet_a: assert property (ctlQ.st == flash_status_pkg::ST_ARRAY && opDone && !opFail &&
    ctlQ.kind == flash_status_pkg::KIND_BULK && !ctlQ.eErr |=> !ctlQ.eErr)
    else $error("bulk erase set erase error");
  err_hold_a: assert property (ctlQ.pErr && !(execNow && (ctlQ.cmd == SOFT_RESET_OP ||
    ctlQ.cmd == flash_status_pkg::CLEAR_STATUS_OP)) |=> ctlQ.pErr)
    else $error("program error lost");
  bulk_gate_a: assert property (ctlQ.start && ctlQ.kind == flash_status_pkg::KIND_BULK |->
    ctlQ.status[flash_status_pkg::BP_MSB:flash_status_pkg::BP_LSB] == 3'h0)
    else $error("bulk erase with protection");
  latch_gate_a: assert property (ctlQ.start |-> $past(ctlQ.write_enable_latch))
    else $error("operation without latch");
  reg_done_a: assert property (ctlQ.st == flash_status_pkg::ST_REG_WRITE && ctlQ.cnt == '0 &&
    !execNow |=> !ctlQ.write_enable_latch && ctlQ.status[flash_status_pkg::BUSY_BIT] == (ctlQ.pErr || ctlQ.eErr))
    else $error("register write end wrong");
  err_busy_a: assert property (ctlQ.eErr |-> ctlQ.status[flash_status_pkg::BUSY_BIT])
    else $error("error without busy");
endmodule

// File: sim/flash_host_model.sv
// Host side serial controller model driving the flash link
`timescale 1ns/100ps
module flash_host_model (
  output logic      sck,
  output logic      csN,
  output logic      mosi,
  input  wire logic misoData,
  input  wire logic misoOeN
);
  initial begin
    sck  = 1'b0;
    csN  = 1'b1;
    mosi = 1'b0;
  end

  // Clock stands still between frames; released mosi shows the inverse of its last bit
  task automatic frame(input logic [23:0] tx, input int nBits, output logic [7:0] rx);
    rx  = 8'h00;
    csN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      mosi = tx[23 - i];
      #7.5;
      sck = 1'b1;
      rx  = {rx[6:0], (misoOeN === 1'b0) ? misoData : 1'bx};
      #7.5;
      sck = 1'b0;
    end
    #7.5;
    csN  = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the flash status register logic
`timescale 1ns/100ps
module testbench;
  logic       clk, srst, sck, csN, mosi, wpN, bpVolatile, areaProtected, opDone, opFail, protHit;
  logic       misoData, misoOeN, opStart, suspendReq;
  logic [1:0] opKind;
  logic [7:0] statusOut, rx;
  int         fails, n_checks, starts, susps;

  // Opcode parameters keep their defaults; the opcode literals below match them
  flash_status_register_logic i_flash_status_register_logic (
    .clk(clk), .srst(srst), .sck(sck), .csN(csN), .mosi(mosi), .wpN(wpN), .bpVolatile(bpVolatile),
    .areaProtected(areaProtected), .opDone(opDone), .opFail(opFail), .protHit(protHit),
    .misoData(misoData), .misoOeN(misoOeN), .opStart(opStart), .opKind(opKind),
    .suspendReq(suspendReq), .statusOut(statusOut));

  flash_host_model i_flash_host_model (.sck(sck), .csN(csN), .mosi(mosi), .misoData(misoData),
    .misoOeN(misoOeN));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulses are one clock wide, so counting them at each edge catches every one
  always @(posedge clk) begin
    if (opStart === 1'b1) starts++;
    if (suspendReq === 1'b1) susps++;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Gap of 8 clocks covers the 4-clock execution sync and the minimum deselect time
  task automatic send(input logic [7:0] op, input logic [7:0] d, input int nBits);
    i_flash_host_model.frame({op, d, 8'h00}, nBits, rx);
    cyc(8);
  endtask

  // Last byte of the read is compared, so only the repeated status byte is checked
  task automatic status(input logic [7:0] exp);
    i_flash_host_model.frame({flash_status_pkg::READ_STATUS_OP, 16'h0000}, 24, rx);
    check("link status", rx, exp);
    check("statusOut", statusOut, exp);
    cyc(8);
  endtask

  task automatic waitIdle;
    int k;
    for (k = 0; k < 60 && statusOut[flash_status_pkg::BUSY_BIT] !== 1'b0; k++) cyc(1);
    if (k == 60) begin
      fails++;
      summarize();
    end
  endtask

  task automatic pulseDone(input logic f, input logic p);
    opFail  = f;
    protHit = p;
    opDone  = 1'b1;
    cyc(1);
    opDone  = 1'b0;
    opFail  = 1'b0;
    protHit = 1'b0;
    cyc(2);
  endtask

  initial begin
    srst = 1'b1;
    wpN = 1'b1;
    bpVolatile = 1'b1;
    areaProtected = 1'b0;
    opDone = 1'b0;
    opFail = 1'b0;
    protHit = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    cyc(2);
    check("reset", statusOut, {3'b000, flash_status_pkg::BP_VOL_RESET, 2'b00});
    bpVolatile = 1'b0;
    cyc(2);
    status(8'h00);
    send(flash_status_pkg::WRITE_REGS_OP, 8'h9c, 16);
    status(8'h00);
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    status(8'h02);
    send(flash_status_pkg::CLEAR_LATCH_OP, 8'h00, 8);
    status(8'h00);
    wpN = 1'b0;
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    send(flash_status_pkg::WRITE_REGS_OP, 8'h8c, 16);
    check("write busy", statusOut, 8'h03);
    waitIdle();
    status(8'h8c);
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    send(flash_status_pkg::WRITE_REGS_OP, 8'h00, 16);
    status(8'h8e);
    wpN = 1'b1;
    cyc(3);
    send(flash_status_pkg::WRITE_REGS_OP, 8'h04, 16);
    status(8'h8f);
    waitIdle();
    status(8'h04);
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    send(8'ha3, 8'h00, 8);
    check("bulk refused", starts[7:0], 8'h00);
    status(8'h06);
    areaProtected = 1'b1;
    send(8'ha1, 8'h00, 8);
    status(8'h47);
    send(flash_status_pkg::CLEAR_LATCH_OP, 8'h00, 8);
    status(8'h47);
    send(flash_status_pkg::CLEAR_STATUS_OP, 8'h00, 8);
    status(8'h06);
    send(flash_status_pkg::CLEAR_LATCH_OP, 8'h00, 8);
    status(8'h04);
    areaProtected = 1'b0;
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    send(flash_status_pkg::WRITE_REGS_OP, 8'h60, 16);
    waitIdle();
    status(8'h00);
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    send(8'ha3, 8'h00, 8);
    check("bulk start", {starts[5:0], opKind}, 8'h06);
    check("bulk busy", statusOut, 8'h03);
    send(8'ha5, 8'h00, 8);
    send(8'ha6, 8'h00, 8);
    check("erase suspend", susps[7:0], 8'h01);
    pulseDone(1'b0, 1'b1);
    status(8'h00);
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    send(8'ha1, 8'h00, 8);
    check("program start", {starts[5:0], opKind}, 8'h08);
    send(8'ha6, 8'h00, 8);
    check("program suspend", susps[7:0], 8'h02);
    pulseDone(1'b1, 1'b0);
    status(8'h43);
    send(flash_status_pkg::CLEAR_STATUS_OP, 8'h00, 8);
    send(flash_status_pkg::CLEAR_LATCH_OP, 8'h00, 8);
    status(8'h00);
    areaProtected = 1'b1;
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    send(8'ha2, 8'h00, 8);
    status(8'h23);
    send(8'ha4, 8'h00, 8);
    status(8'h00);
    bpVolatile = 1'b1;
    cyc(2);
    status(8'h1c);
    send(flash_status_pkg::SET_LATCH_OP, 8'h00, 8);
    send(flash_status_pkg::WRITE_REGS_OP, 8'h08, 16);
    waitIdle();
    status(8'h08);
    bpVolatile = 1'b0;
    cyc(2);
    status(8'h00);
    summarize();
  end
endmodule
